// *** bciw_regs.sv ***
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "bciw_defs.svh"

module bciw_regs #(
   parameter int ADDR_W = 12, // APB byte address width
   parameter int CNT_W = 16 // Width of each forwarding counter
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Upper halves of the I/O window from the neighbouring block
   input wire logic [15:0] io_upper_base,
   input wire logic [15:0] io_upper_limit,
   // I/O requests to be routed
   input wire logic io_req_valid,
   input wire logic io_req_from_secondary,
   input wire logic [31:0] io_req_addr,
   // Routing decisions
   output logic io_fwd_downstream,
   output logic io_fwd_upstream,
   // Configuration seen by the rest of the bridge
   output logic [7:0] upstream_segment_number,
   output logic [7:0] downstream_segment_number,
   output logic [7:0] highest_segment_behind,
   output logic io_addr_width_flag
);

   // Decoded phases of the bus
   logic setup_phase; // First cycle of a transfer
   logic access_phase; // Completing cycle, zero wait states
   logic wr_lane0; // Write that carries the low byte lane

   // Register selections
   bciw_pkg::bciw_reg_t rd_sel; // Target of the read snapshot
   bciw_pkg::bciw_reg_t wr_sel; // Target of a completing write

   // Register storage
   logic [3:0] io_low_nibble; // Window base bits 15:12
   logic [3:0] io_high_nibble; // Window limit bits 15:12
   logic width_lock; // Freezes the width flag once set
   logic [CNT_W-1:0] down_count; // Downstream forwards seen
   logic [CNT_W-1:0] up_count; // Upstream forwards seen
   logic stats_clear; // Software clears both counters

   // Read mux output
   logic [31:0] next_prdata;
   logic next_pslverr;

   // Map a byte address to a register; used by read and write paths
   function automatic bciw_pkg::bciw_reg_t decode_reg(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] idx;
      idx = {2'b00, addr[ADDR_W-1:2]};
      decode_reg = bciw_pkg::REG_NONE;
      // Misaligned byte addresses never select a register
      if (addr[1:0] == 2'b00) begin
         case (idx)
            `BCIW_IDX_PRI_LAT: decode_reg = bciw_pkg::REG_PRI_LAT;
            `BCIW_IDX_HEADER_TYPE: decode_reg = bciw_pkg::REG_HEADER_TYPE;
            `BCIW_IDX_SELF_TEST: decode_reg = bciw_pkg::REG_SELF_TEST;
            `BCIW_IDX_BASE_WIN0: decode_reg = bciw_pkg::REG_BASE_WIN;
            `BCIW_IDX_BASE_WIN1: decode_reg = bciw_pkg::REG_BASE_WIN;
            `BCIW_IDX_UP_SEG: decode_reg = bciw_pkg::REG_UP_SEG;
            `BCIW_IDX_DOWN_SEG: decode_reg = bciw_pkg::REG_DOWN_SEG;
            `BCIW_IDX_HIGH_SEG: decode_reg = bciw_pkg::REG_HIGH_SEG;
            `BCIW_IDX_DOWN_LAT: decode_reg = bciw_pkg::REG_DOWN_LAT;
            `BCIW_IDX_IO_LOW: decode_reg = bciw_pkg::REG_IO_LOW;
            `BCIW_IDX_IO_HIGH: decode_reg = bciw_pkg::REG_IO_HIGH;
            `BCIW_IDX_LOCK: decode_reg = bciw_pkg::REG_LOCK;
            `BCIW_IDX_STATS: decode_reg = bciw_pkg::REG_STATS;
            default: decode_reg = bciw_pkg::REG_NONE;
         endcase
      end
   endfunction : decode_reg

   // Bus phases
   assign setup_phase = psel && !penable;
   assign access_phase = psel && penable;

   // Registers only use the low lane; upper lanes carry nothing to store
   assign wr_lane0 = access_phase && pwrite && pstrb[0];

   // Read data is snapshotted in setup, so the slave never inserts waits
   assign pready = 1'b1;

   // Address decode for each direction
   assign rd_sel = decode_reg(paddr);
   assign wr_sel = wr_lane0 ? decode_reg(paddr) : bciw_pkg::REG_NONE;

   // Read mux; fixed bytes and reserved bits come back as constants
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      case (rd_sel)
         bciw_pkg::REG_PRI_LAT: begin
            next_prdata[7:0] = `BCIW_VAL_PRI_LAT;
         end
         bciw_pkg::REG_HEADER_TYPE: begin
            next_prdata[7:0] = `BCIW_VAL_HEADER_TYPE;
         end
         bciw_pkg::REG_SELF_TEST: begin
            next_prdata[7:0] = `BCIW_VAL_SELF_TEST;
         end
         bciw_pkg::REG_BASE_WIN: begin
            next_prdata = `BCIW_VAL_BASE_WIN;
         end
         bciw_pkg::REG_UP_SEG: begin
            next_prdata[7:0] = upstream_segment_number;
         end
         bciw_pkg::REG_DOWN_SEG: begin
            next_prdata[7:0] = downstream_segment_number;
         end
         bciw_pkg::REG_HIGH_SEG: begin
            next_prdata[7:0] = highest_segment_behind;
         end
         bciw_pkg::REG_DOWN_LAT: begin
            next_prdata[7:0] = `BCIW_VAL_DOWN_LAT;
         end
         bciw_pkg::REG_IO_LOW: begin
            // Bits 3:1 are reserved and stay zero
            next_prdata[`BCIW_FLD_FLAG] = io_addr_width_flag;
            next_prdata[`BCIW_FLD_ADDR_HI:`BCIW_FLD_ADDR_LO] = io_low_nibble;
         end
         bciw_pkg::REG_IO_HIGH: begin
            // Flag here is a live copy, never separate storage
            next_prdata[`BCIW_FLD_FLAG] = io_addr_width_flag;
            next_prdata[`BCIW_FLD_ADDR_HI:`BCIW_FLD_ADDR_LO] = io_high_nibble;
         end
         bciw_pkg::REG_LOCK: begin
            next_prdata[`BCIW_FLD_LOCK] = width_lock;
         end
         bciw_pkg::REG_STATS: begin
            next_prdata[CNT_W-1:0] = down_count;
            next_prdata[2*CNT_W-1:CNT_W] = up_count;
         end
         bciw_pkg::REG_NONE: begin
            // Unmapped word: zero data and an error answer
            next_pslverr = 1'b1;
         end
         default: begin
            next_pslverr = 1'b1;
         end
      endcase
   end

   // Read data and error answer, taken in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup_phase) begin
         // Writes answer with zero data but keep the error flag
         prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         pslverr <= next_pslverr;
      end else if (!psel) begin
         // Idle bus: drop the answer
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   // Bus segment numbers, stored for software and driven to the rest of the bridge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         upstream_segment_number <= `BCIW_RST_SEG;
         downstream_segment_number <= `BCIW_RST_SEG;
         highest_segment_behind <= `BCIW_RST_SEG;
      end else begin
         // Upstream number has no effect inside the bridge
         if (wr_sel == bciw_pkg::REG_UP_SEG) begin
            upstream_segment_number <= pwdata[7:0];
         end
         // Number of the segment on the secondary side
         if (wr_sel == bciw_pkg::REG_DOWN_SEG) begin
            downstream_segment_number <= pwdata[7:0];
         end
         // Highest segment reachable behind the bridge
         if (wr_sel == bciw_pkg::REG_HIGH_SEG) begin
            highest_segment_behind <= pwdata[7:0];
         end
      end
   end

   // Lock for the width flag; only reset can release it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         width_lock <= 1'b0;
      end else if (wr_sel == bciw_pkg::REG_LOCK && pwdata[`BCIW_FLD_LOCK]) begin
         width_lock <= 1'b1;
      end
   end

   // Addressing width flag, writable until locked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_addr_width_flag <= `BCIW_RST_WIDTH_FLAG;
      end else if (wr_sel == bciw_pkg::REG_IO_LOW && !width_lock) begin
         io_addr_width_flag <= pwdata[`BCIW_FLD_FLAG];
      end
   end

   // Window base nibble; reserved bits 3:1 are not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_low_nibble <= `BCIW_RST_IO_LOW;
      end else if (wr_sel == bciw_pkg::REG_IO_LOW) begin
         io_low_nibble <= pwdata[`BCIW_FLD_ADDR_HI:`BCIW_FLD_ADDR_LO];
      end
   end

   // Window limit nibble; bit 0 written here is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_high_nibble <= `BCIW_RST_IO_HIGH;
      end else if (wr_sel == bciw_pkg::REG_IO_HIGH) begin
         io_high_nibble <= pwdata[`BCIW_FLD_ADDR_HI:`BCIW_FLD_ADDR_LO];
      end
   end

   // Any write to the statistics word that carries the low byte lane clears both counters
   assign stats_clear = (wr_sel == bciw_pkg::REG_STATS);

   // Window compare and routing pulses
   bciw_io_window u_window (
      .pclk(pclk),
      .presetn(presetn),
      .low_nibble(io_low_nibble),
      .high_nibble(io_high_nibble),
      .io_addr_width_flag(io_addr_width_flag),
      .io_upper_base(io_upper_base),
      .io_upper_limit(io_upper_limit),
      .io_req_valid(io_req_valid),
      .io_req_from_secondary(io_req_from_secondary),
      .io_req_addr(io_req_addr),
      .io_fwd_downstream(io_fwd_downstream),
      .io_fwd_upstream(io_fwd_upstream)
   );

   // Downstream counter; an event in the clear cycle still counts
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         down_count <= '0;
      end else if (stats_clear) begin
         down_count <= io_fwd_downstream ? CNT_W'(1) : '0;
      end else if (io_fwd_downstream) begin
         // Wraps silently; software samples often enough
         down_count <= down_count + CNT_W'(1);
      end
   end

   // Upstream counter, same clear priority
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_count <= '0;
      end else if (stats_clear) begin
         up_count <= io_fwd_upstream ? CNT_W'(1) : '0;
      end else if (io_fwd_upstream) begin
         up_count <= up_count + CNT_W'(1);
      end
   end

   // Writes to fixed bytes and base windows select nothing that stores

endmodule : bciw_regs
`default_nettype wire

// *** bciw_defs.svh ***
`ifndef BCIW_DEFS_SVH
`define BCIW_DEFS_SVH

// Register indices; byte address is four times the index
`define BCIW_IDX_PRI_LAT 12'h00D
`define BCIW_IDX_HEADER_TYPE 12'h00E
`define BCIW_IDX_SELF_TEST 12'h00F
`define BCIW_IDX_BASE_WIN0 12'h010
`define BCIW_IDX_BASE_WIN1 12'h014
`define BCIW_IDX_UP_SEG 12'h018
`define BCIW_IDX_DOWN_SEG 12'h019
`define BCIW_IDX_HIGH_SEG 12'h01A
`define BCIW_IDX_DOWN_LAT 12'h01B
`define BCIW_IDX_IO_LOW 12'h01C
`define BCIW_IDX_IO_HIGH 12'h01D
`define BCIW_IDX_LOCK 12'h040
`define BCIW_IDX_STATS 12'h041

// Fixed read values
`define BCIW_VAL_PRI_LAT 8'h00
`define BCIW_VAL_HEADER_TYPE 8'h01
`define BCIW_VAL_SELF_TEST 8'h00
`define BCIW_VAL_BASE_WIN 32'h0000_0000
`define BCIW_VAL_DOWN_LAT 8'h00

// Reset values
`define BCIW_RST_SEG 8'h00
`define BCIW_RST_WIDTH_FLAG 1'b1
`define BCIW_RST_IO_LOW 4'hF
`define BCIW_RST_IO_HIGH 4'h0

// Field positions inside the I/O bound bytes and the lock word
`define BCIW_FLD_FLAG 0
`define BCIW_FLD_ADDR_LO 4
`define BCIW_FLD_ADDR_HI 7
`define BCIW_FLD_LOCK 0

// Address pieces of the I/O window
`define BCIW_IO_PAGE_LOW 12'h000
`define BCIW_IO_PAGE_HIGH 12'hFFF

`endif

// *** bciw_pkg.sv ***
`default_nettype none
package bciw_pkg;

   // Register selected by an APB address
   typedef enum logic [3:0] {
      REG_NONE = 4'h0,
      REG_PRI_LAT = 4'h1,
      REG_HEADER_TYPE = 4'h2,
      REG_SELF_TEST = 4'h3,
      REG_BASE_WIN = 4'h4,
      REG_UP_SEG = 4'h5,
      REG_DOWN_SEG = 4'h6,
      REG_HIGH_SEG = 4'h7,
      REG_DOWN_LAT = 4'h8,
      REG_IO_LOW = 4'h9,
      REG_IO_HIGH = 4'hA,
      REG_LOCK = 4'hB,
      REG_STATS = 4'hC
   } bciw_reg_t;

endpackage : bciw_pkg
`default_nettype wire

// *** bciw_io_window.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bciw_defs.svh"

module bciw_io_window (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Programmed window
   input wire logic [3:0] low_nibble,
   input wire logic [3:0] high_nibble,
   input wire logic io_addr_width_flag,
   input wire logic [15:0] io_upper_base,
   input wire logic [15:0] io_upper_limit,
   // Incoming I/O request
   input wire logic io_req_valid,
   input wire logic io_req_from_secondary,
   input wire logic [31:0] io_req_addr,
   // Registered decision, one-cycle pulses
   output logic io_fwd_downstream,
   output logic io_fwd_upstream
);

   logic [31:0] win_low; // Lowest claimed address, 4KB aligned
   logic [31:0] win_high; // Highest claimed address, low 12 bits all ones
   logic in_window; // Address falls inside the window

   // Narrow addressing drops the upper halves, so only the low 64K can hit
   always_comb begin
      if (io_addr_width_flag) begin
         win_low = {io_upper_base, low_nibble, `BCIW_IO_PAGE_LOW};
         win_high = {io_upper_limit, high_nibble, `BCIW_IO_PAGE_HIGH};
      end else begin
         win_low = {16'h0000, low_nibble, `BCIW_IO_PAGE_LOW};
         win_high = {16'h0000, high_nibble, `BCIW_IO_PAGE_HIGH};
      end
   end

   // Inclusive compare; an inverted window can never hit
   assign in_window = (io_req_addr >= win_low) && (io_req_addr <= win_high);

   // Decision is registered so downstream logic sees a clean pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_fwd_downstream <= 1'b0;
         io_fwd_upstream <= 1'b0;
      end else begin
         io_fwd_downstream <= io_req_valid && !io_req_from_secondary && in_window;
         io_fwd_upstream <= io_req_valid && io_req_from_secondary && !in_window;
      end
   end

endmodule : bciw_io_window
`default_nettype wire

// *** bciw_regs_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module bciw_regs_chk #(
   parameter int ADDR_W = 12,
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Routing side
   input wire logic io_req_valid,
   input wire logic io_req_from_secondary,
   input wire logic io_fwd_downstream,
   input wire logic io_fwd_upstream,
   // Configuration outputs
   input wire logic [7:0] upstream_segment_number,
   input wire logic [7:0] downstream_segment_number,
   input wire logic [7:0] highest_segment_behind,
   input wire logic io_addr_width_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Write byte of the previous edge, compared after a write lands
   logic [7:0] wr_byte;
   always_ff @(posedge pclk) begin
      wr_byte <= pwdata[7:0];
   end
   // Read setup and committed write to one address
   sequence rd_at(logic [ADDR_W-1:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   sequence wr_at(logic [ADDR_W-1:0] a);
      psel && penable && pwrite && pstrb[0] && paddr == a;
   endsequence
   AST_ZERO_LAT: assert property ((rd_at(12'h034) or rd_at(12'h06C)) |=> prdata == 32'h0)
      else $error("latency byte not zero");
   AST_HEADER_TYPE: assert property (rd_at(12'h038) |=> prdata == 32'h1 && !pslverr)
      else $error("header type wrong");
   AST_SELF_TEST: assert property (rd_at(12'h03C) |=> prdata == 32'h0)
      else $error("self test byte not zero");
   AST_BASE_WIN: assert property ((rd_at(12'h040) or rd_at(12'h050)) |=> prdata == 32'h0)
      else $error("unused window not zero");
   AST_UP_SEG: assert property (wr_at(12'h060) |=> upstream_segment_number == wr_byte)
      else $error("upstream segment not written");
   AST_DOWN_SEG: assert property (wr_at(12'h064) |=> downstream_segment_number == wr_byte)
      else $error("downstream segment not written");
   AST_HIGH_SEG: assert property (wr_at(12'h068) |=> highest_segment_behind == wr_byte)
      else $error("highest segment not written");
   AST_MIRROR: assert property (rd_at(12'h074) |=> prdata[0] == $past(io_addr_width_flag))
      else $error("width flag mirror wrong");
   AST_RESET_VAL: assert property ($rose(presetn) |-> io_addr_width_flag && upstream_segment_number == 8'h00)
      else $error("reset values wrong");
   AST_DOWN_CAUSE: assert property (io_fwd_downstream |-> $past(io_req_valid) && !$past(io_req_from_secondary))
      else $error("downstream pulse without primary request");
   AST_UP_CAUSE: assert property (io_fwd_upstream |-> $past(io_req_valid) && $past(io_req_from_secondary))
      else $error("upstream pulse without secondary request");
   AST_MISALIGN: assert property (psel && !penable && paddr[1:0] != 2'b00 |=> pslverr && prdata == 32'h0)
      else $error("misaligned access not refused");
endmodule : bciw_regs_chk
bind bciw_regs bciw_regs_chk #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pslverr(pslverr), .io_req_valid(io_req_valid), .io_req_from_secondary(io_req_from_secondary),
   .io_fwd_downstream(io_fwd_downstream), .io_fwd_upstream(io_fwd_upstream),
   .upstream_segment_number(upstream_segment_number), .downstream_segment_number(downstream_segment_number),
   .highest_segment_behind(highest_segment_behind), .io_addr_width_flag(io_addr_width_flag));
`default_nettype wire

// *** bciw_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module bciw_regs_tb;
   // Clock, reset and APB drive
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, a, lo, hi;
   logic [3:0] pstrb = 4'h0;
   logic pready, pslverr, er, v, s;
   // Request side; the limit's upper half sits one above the base's
   logic [15:0] io_upper = 16'h0, io_upper_hi;
   logic io_req_valid = 1'b0, io_req_from_secondary = 1'b0, io_fwd_downstream, io_fwd_upstream, flag;
   logic [31:0] io_req_addr = 32'h0;
   logic [7:0] seg_up, seg_dn, seg_hi;
   // Reference model
   logic [7:0] m_seg [3];
   logic [3:0] m_base, m_limit;
   logic m_flag, m_lock;
   int m_dn, m_up, fail_count = 0, num_checks = 0;
   logic [11:0] amap [12] = '{12'h034, 12'h038, 12'h03C, 12'h040, 12'h050, 12'h060, 12'h064, 12'h068,
      12'h06C, 12'h070, 12'h074, 12'h104};
   logic [7:0] wins [4] = '{8'h12, 8'hF0, 8'h55, 8'h0F};

   always #2.5 pclk = ~pclk;
   assign io_upper_hi = io_upper + 16'h0001;

   bciw_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .io_upper_base(io_upper), .io_upper_limit(io_upper_hi), .io_req_valid(io_req_valid),
      .io_req_from_secondary(io_req_from_secondary), .io_req_addr(io_req_addr),
      .io_fwd_downstream(io_fwd_downstream), .io_fwd_upstream(io_fwd_upstream),
      .upstream_segment_number(seg_up), .downstream_segment_number(seg_dn),
      .highest_segment_behind(seg_hi), .io_addr_width_flag(flag));

   // Verdict and end of run
   task automatic wrap_up();
      if (fail_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up

   // One comparison
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Expected {error, data} of a read
   function automatic logic [32:0] mrd(input logic [11:0] ad);
      case (ad)
         12'h034, 12'h03C, 12'h040, 12'h050, 12'h06C: return 33'h0;
         12'h038: return 33'h1;
         12'h060: return {25'h0, m_seg[0]};
         12'h064: return {25'h0, m_seg[1]};
         12'h068: return {25'h0, m_seg[2]};
         12'h070: return {25'h0, m_base, 3'b000, m_flag};
         12'h074: return {25'h0, m_limit, 3'b000, m_flag};
         12'h100: return {32'h0, m_lock};
         12'h104: return {1'b0, m_up[15:0], m_dn[15:0]};
         default: return {1'b1, 32'h0};
      endcase
   endfunction : mrd

   // Model of a committed write; strobe 0 means nothing stored
   task automatic mwr(input logic [11:0] ad, input logic [31:0] d, input logic [3:0] st);
      if (st[0]) begin
         case (ad)
            12'h060: m_seg[0] = d[7:0];
            12'h064: m_seg[1] = d[7:0];
            12'h068: m_seg[2] = d[7:0];
            12'h070: begin
               m_base = d[7:4];
               if (!m_lock) m_flag = d[0];
            end
            12'h074: m_limit = d[7:4];
            12'h100: m_lock = m_lock | d[0];
            12'h104: begin
               m_dn = 0;
               m_up = 0;
            end
            default: ;
         endcase
      end
   endtask : mwr

   // Model state after any reset
   task automatic mreset();
      m_seg = '{default: 8'h00};
      m_base = 4'hF;
      m_limit = 4'h0;
      m_flag = 1'b1;
      m_lock = 1'b0;
      m_dn = 0;
      m_up = 0;
   endtask : mreset

   // APB transfer, then comparison with the model
   task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] st);
      int n;
      logic [32:0] exp;
      exp = mrd(ad);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      pstrb <= st;
      @(posedge pclk);
      penable <= 1'b1;
      // Configuration outputs, settled since the last write landed
      chk("cfg", {8'h0, seg_up, seg_dn, seg_hi, flag}, {8'h0, m_seg[0], m_seg[1], m_seg[2], m_flag});
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         wrap_up();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (w) begin
         chk($sformatf("werr %h", ad), {32'h0, er}, {32'h0, exp[32]});
         mwr(ad, d, st);
      end else chk($sformatf("reg %h", ad), {er, rd}, exp);
   endtask : xfer

   // Back-to-back requests; each pulse checked one edge later
   task automatic run(input int n);
      logic p_dn, p_up;
      p_dn = 1'b0;
      p_up = 1'b0;
      for (int i = 0; i <= n; i++) begin
         @(posedge pclk);
         v = (i < n) && ($urandom_range(3) != 0);
         s = 1'($urandom_range(1));
         // Upper half aimed at the base page, the limit page or anywhere
         case ($urandom_range(2))
            0: a[31:16] = 16'($urandom);
            1: a[31:16] = m_flag ? io_upper : 16'h0;
            default: a[31:16] = m_flag ? io_upper_hi : 16'h0;
         endcase
         a[15:0] = 16'($urandom);
         io_req_valid <= v;
         io_req_from_secondary <= s;
         io_req_addr <= a;
         #1;
         chk("fwd", {31'h0, io_fwd_downstream, io_fwd_upstream}, {31'h0, p_dn, p_up});
         lo = {m_flag ? io_upper : 16'h0, m_base, 12'h000};
         hi = {m_flag ? io_upper_hi : 16'h0, m_limit, 12'hFFF};
         p_dn = v && !s && a >= lo && a <= hi;
         p_up = v && s && !(a >= lo && a <= hi);
         m_dn += int'(p_dn);
         m_up += int'(p_up);
      end
   endtask : run

   // Hang guard
   initial begin
      #100000;
      fail_count++;
      wrap_up();
   end

   // Main sequence
   initial begin
      void'($urandom(98));
      mreset();
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (amap[i]) xfer(1'b0, amap[i], 32'h0, 4'h0);
      foreach (amap[i]) begin
         xfer(1'b1, amap[i], $urandom, 4'hF);
         xfer(1'b0, amap[i], 32'h0, 4'h0);
      end
      xfer(1'b1, 12'h064, 32'h0000_00A5, 4'hE);
      xfer(1'b0, 12'h064, 32'h0, 4'h0);
      xfer(1'b0, 12'h061, 32'h0, 4'h0);
      xfer(1'b1, 12'h0F0, 32'hFFFF_FFFF, 4'hF);
      xfer(1'b0, 12'h0F0, 32'h0, 4'h0);
      for (int f = 0; f < 2; f++) begin
         foreach (wins[w]) begin
            xfer(1'b1, 12'h070, {24'h0, wins[w][7:4], 3'b000, 1'(f)}, 4'hF);
            xfer(1'b1, 12'h074, {24'h0, wins[w][3:0], 4'h0}, 4'hF);
            io_upper <= 16'($urandom);
            run(40);
            xfer(1'b0, 12'h104, 32'h0, 4'h0);
         end
      end
      xfer(1'b1, 12'h100, 32'h1, 4'hF);
      xfer(1'b0, 12'h100, 32'h0, 4'h0);
      xfer(1'b1, 12'h070, {24'h0, 4'h3, 3'b000, ~m_flag}, 4'hF);
      xfer(1'b0, 12'h070, 32'h0, 4'h0);
      xfer(1'b0, 12'h074, 32'h0, 4'h0);
      // Mid-run reset must release the lock and restore every field
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      mreset();
      foreach (amap[i]) xfer(1'b0, amap[i], 32'h0, 4'h0);
      xfer(1'b0, 12'h100, 32'h0, 4'h0);
      wrap_up();
   end
endmodule : bciw_regs_tb
`default_nettype wire
